/* hw/amd_decoder.sv */
// Purpose: Addressing mode decoder between fetch and execution.
// Assumes: Fetch presents bytes in program order with their addresses.
// Notes:   One instruction in flight; the result is held until taken.
//
// Operation
// RL1: Accumulator mode is one byte, opcode picks accumulator
// RL2: Push/pull accumulator-only; other eleven also indexed/extended
// RL3: Add-accumulators reads A and B, writes A
// RL4: Inherent instructions are one byte, no operands
// RL5: 8-bit immediate is two bytes, operand byte two
// RL6: 8-bit immediate operand is unsigned 0 to 255
// RL7: Index/stack immediates are three bytes, high first
// RL8: Immediate address is the byte after opcode
// RL9: Character immediates arrive with bit 7 clear
// RL10: Branches are two bytes, signed 8-bit displacement
// RL11: Branch target is first byte plus 2 plus displacement
// RL12: Relative mode only for branches, branches only relative
// RL13: Jumps never use relative mode
// RL14: Indexed mode is two bytes, unsigned offset
// RL15: Indexed address is offset plus index register
// RL16: Zero offset uses index register unchanged
// RL17: Direct mode is two bytes, first 256 locations
// RL18: Extended mode is three bytes, high byte first
// RL19: Mode comes from the opcode byte alone
// RL20: Exactly 197 opcode values are valid
// RL21: Indexed and relative sums wrap at 16 bits
`include "amd_cfg.svh"
`default_nettype none

module amd_decoder (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Byte stream from program memory
  input wire logic fetch_valid,
  input wire amd_pkg::amd_fetch_t fetch_in,
  output logic fetch_ready,
  // Execution side
  input wire logic [15:0] index_reg,
  input wire logic res_ready,
  output logic res_valid,
  output amd_pkg::amd_res_t res,
  // Status
  output logic illegal_q
);
  import amd_pkg::*;

  // --------------------------------------------------------------------
  // Declarations
  // --------------------------------------------------------------------
  amd_state_t state_q;
  amd_state_t state_d;
  amd_dec_t dec_new;
  amd_dec_t dec_q;
  amd_dec_t dec_cur;
  amd_res_t res_q;
  amd_res_t res_d;
  logic [7:0] opcode_q;
  logic [7:0] opcode_cur;
  logic [15:0] opc_addr_q;
  logic [15:0] opc_addr_cur;
  logic [7:0] byte2_q;
  logic [7:0] byte2_d;
  logic [7:0] byte3_q;
  logic [7:0] byte3_d;
  logic take;
  logic go_res;
  logic in_opc;
  logic [15:0] operand_d;
  logic [15:0] ea_d;

  // --------------------------------------------------------------------
  // Opcode decode and address arithmetic
  // --------------------------------------------------------------------

  // Decode straight from the incoming byte so the length is known at once
  amd_opcode_table u_table (
    .opcode(fetch_in.data),
    .dec(dec_new)
  );

  amd_ea_calc u_ea (
    .mode(dec_cur.mode),
    .wide(dec_cur.wide),
    .opc_addr(opc_addr_cur),
    .byte2(byte2_d),
    .byte3(byte3_d),
    .index_reg(index_reg),
    .operand(operand_d),
    .ea(ea_d)
  );

  // --------------------------------------------------------------------
  // Handshakes
  // --------------------------------------------------------------------

  // Bytes are accepted in every state but the result hold
  assign in_opc = (state_q == AMD_ST_OPC);
  assign fetch_ready = (state_q != AMD_ST_RES);
  assign take = fetch_valid && fetch_ready;
  assign res_valid = (state_q == AMD_ST_RES);
  assign res = res_q;

  // The opcode cycle uses live values, later cycles the stored ones
  assign dec_cur = in_opc ? dec_new : dec_q; // RL19
  assign opcode_cur = in_opc ? fetch_in.data : opcode_q;
  assign opc_addr_cur = in_opc ? fetch_in.addr : opc_addr_q;

  // Last byte of the instruction closes it
  always_comb begin
    go_res = 1'b0;
    if (take) begin
      case (state_q)
        AMD_ST_OPC: go_res = (dec_new.len == `AMD_LEN_ONE); // RL1 RL4
        AMD_ST_OP1: go_res = (dec_q.len == `AMD_LEN_TWO);
        AMD_ST_OP2: go_res = 1'b1;
        default: go_res = 1'b0;
      endcase
    end
  end

  // --------------------------------------------------------------------
  // Operand bytes
  // --------------------------------------------------------------------

  // Missing operand bytes read as zero so stale data never leaks through
  always_comb begin
    case (state_q)
      AMD_ST_OPC: begin
        byte2_d = 8'h00;
        byte3_d = 8'h00;
      end
      AMD_ST_OP1: begin
        byte2_d = take ? fetch_in.data : byte2_q;
        byte3_d = 8'h00;
      end
      AMD_ST_OP2: begin
        byte2_d = byte2_q;
        byte3_d = take ? fetch_in.data : byte3_q;
      end
      default: begin
        byte2_d = byte2_q;
        byte3_d = byte3_q;
      end
    endcase
  end

  // Operand byte registers
  always_ff @(posedge clk) begin
    if (reset) begin
      byte2_q <= 8'h00;
      byte3_q <= 8'h00;
    end else begin
      byte2_q <= byte2_d;
      byte3_q <= byte3_d;
    end
  end

  // --------------------------------------------------------------------
  // Opcode capture
  // --------------------------------------------------------------------

  // Decode is stored once; operand bytes never alter it
  always_ff @(posedge clk) begin
    if (reset) begin
      opcode_q <= 8'h00;
      opc_addr_q <= 16'h0000;
      dec_q <= '0;
    end else if (take && in_opc) begin
      opcode_q <= fetch_in.data;
      opc_addr_q <= fetch_in.addr;
      dec_q <= dec_new; // RL19
    end
  end

  // --------------------------------------------------------------------
  // Sequencer
  // --------------------------------------------------------------------

  // Byte count follows the decoded length
  always_comb begin
    state_d = state_q;
    case (state_q)
      AMD_ST_OPC: begin
        if (take) begin
          state_d = go_res ? AMD_ST_RES : AMD_ST_OP1;
        end
      end
      AMD_ST_OP1: begin
        if (take) begin
          state_d = go_res ? AMD_ST_RES : AMD_ST_OP2; // RL7 RL18
        end
      end
      AMD_ST_OP2: begin
        if (take) begin
          state_d = AMD_ST_RES;
        end
      end
      AMD_ST_RES: begin
        if (res_ready) begin
          state_d = AMD_ST_OPC;
        end
      end
      default: state_d = AMD_ST_OPC;
    endcase
  end

  // State register
  always_ff @(posedge clk) begin
    if (reset) begin
      state_q <= AMD_ST_OPC;
    end else begin
      state_q <= state_d;
    end
  end

  // --------------------------------------------------------------------
  // Result
  // --------------------------------------------------------------------

  // Index register is sampled on the last byte, not when execution takes the result
  always_comb begin
    res_d.opcode = opcode_cur;
    res_d.opc_addr = opc_addr_cur;
    res_d.dec = dec_cur;
    res_d.operand = (dec_cur.mode == AMD_MODE_IMM) ? operand_d : 16'h0000;
    res_d.ea = ea_d; // RL15 RL21
    res_d.next_pc = 16'(opc_addr_cur + {14'h0000, dec_cur.len}); // RL21
  end

  // Result register, held while execution stalls
  always_ff @(posedge clk) begin
    if (reset) begin
      res_q <= '0;
    end else if (go_res) begin
      res_q <= res_d;
    end
  end

  // Sticky until reset: an unassigned opcode was seen
  always_ff @(posedge clk) begin
    if (reset) begin
      illegal_q <= 1'b0;
    end else if (go_res && !dec_cur.valid) begin
      illegal_q <= 1'b1; // RL20
    end
  end

endmodule

`default_nettype wire

/* hw/amd_cfg.svh */
// Purpose: Constants of the addressing mode decoder.
// Assumes: Included by the design modules and the bench top.
// Notes:   Definitions only; no logic lives here.
`ifndef AMD_CFG_SVH
`define AMD_CFG_SVH

// ----
// Instruction lengths in bytes
// ----
`define AMD_LEN_ONE 2'h1
`define AMD_LEN_TWO 2'h2
`define AMD_LEN_THREE 2'h3

// ----
// Opcode field positions and group codes
// ----
`define AMD_ROW_MSB 7
`define AMD_ROW_LSB 4
`define AMD_GRP_MSB 7
`define AMD_GRP_LSB 6
`define AMD_SUB_MSB 5
`define AMD_SUB_LSB 4
`define AMD_GRP_LOW 2'h0
`define AMD_GRP_SGL 2'h1
`define AMD_ROW_REL 4'h2
`define AMD_SUB_IMM 2'h0
`define AMD_SUB_DIR 2'h1
`define AMD_SUB_IDX 2'h2
`define AMD_SUB_EXT 2'h3
`define AMD_ACCB_BIT 4
`define AMD_STK_ACCB_BIT 0

// ----
// Opcodes with special addressing treatment
// ----
`define AMD_OPC_ADD_ACC 8'h1B
`define AMD_OPC_CMP_IDX 8'h8C
`define AMD_OPC_LD_SP 8'h8E
`define AMD_OPC_LD_IDX 8'hCE
`define AMD_OPC_BR_SUB 8'h8D
`define AMD_OPC_PULL_A 8'h32
`define AMD_OPC_PULL_B 8'h33
`define AMD_OPC_PUSH_A 8'h36
`define AMD_OPC_PUSH_B 8'h37

// ----
// Valid opcode masks, one 16-bit column mask per upper nibble
// ----
`define AMD_MASK_ROW0 16'hFFC2
`define AMD_MASK_ROW1 16'h0AC3
`define AMD_MASK_ROW2 16'hFFFD
`define AMD_MASK_ROW3 16'hCAFF
`define AMD_MASK_ROW45 16'hB7D9
`define AMD_MASK_ROW67 16'hF7D9
`define AMD_MASK_ROW8 16'h7F77
`define AMD_MASK_ROW9 16'hDFF7
`define AMD_MASK_ROWAB 16'hFFF7
`define AMD_MASK_ROWC 16'h4F77
`define AMD_MASK_ROWDF 16'hCFF7

// ----
// Address arithmetic
// ----
`define AMD_REL_BIAS 16'h0002
`define AMD_IMM_STEP 16'h0001
`define AMD_ZERO_PAGE 8'h00

`endif

/* hw/amd_pkg.sv */
// Purpose: Types shared by the addressing mode decoder.
// Assumes: Stands alone; no constants come from amd_cfg.svh.
// Notes:   Modes are one-hot so a consumer can test a single bit.
`default_nettype none

package amd_pkg;

  // ----
  // Addressing modes
  // ----
  typedef enum logic [7:0] {
    AMD_MODE_INH = 8'h01,
    AMD_MODE_ACC = 8'h02,
    AMD_MODE_IMM = 8'h04,
    AMD_MODE_REL = 8'h08,
    AMD_MODE_IDX = 8'h10,
    AMD_MODE_DIR = 8'h20,
    AMD_MODE_EXT = 8'h40,
    AMD_MODE_ILL = 8'h80
  } amd_mode_t;

  // ----
  // Decoder states
  // ----
  typedef enum logic [3:0] {
    AMD_ST_OPC = 4'h1,
    AMD_ST_OP1 = 4'h2,
    AMD_ST_OP2 = 4'h4,
    AMD_ST_RES = 4'h8
  } amd_state_t;

  // ----
  // Carriers
  // ----
  typedef struct packed {
    logic [7:0] data;
    logic [15:0] addr;
  } amd_fetch_t;

  typedef struct packed {
    logic valid;
    amd_mode_t mode;
    logic [1:0] len;
    logic wide;
    logic [1:0] acc_rd;
    logic [1:0] acc_wr;
  } amd_dec_t;

  typedef struct packed {
    logic [7:0] opcode;
    logic [15:0] opc_addr;
    amd_dec_t dec;
    logic [15:0] operand;
    logic [15:0] ea;
    logic [15:0] next_pc;
  } amd_res_t;

endpackage

`default_nettype wire

/* hw/amd_opcode_table.sv */
// Purpose: Maps an opcode byte to validity, mode, length and accumulators.
// Assumes: Pure combinational; the opcode byte is the only input.
// Notes:   Accumulator masks use bit 0 for A and bit 1 for B.
`include "amd_cfg.svh"
`default_nettype none

module amd_opcode_table (
  // Opcode in
  input wire logic [7:0] opcode,
  // Decode out
  output var amd_pkg::amd_dec_t dec
);
  import amd_pkg::*;

  // --------------------------------------------------------------------
  // Valid column mask of one opcode row
  // --------------------------------------------------------------------
  function automatic logic [15:0] row_mask(input logic [3:0] row);
    case (row)
      4'h0: row_mask = `AMD_MASK_ROW0;
      4'h1: row_mask = `AMD_MASK_ROW1;
      4'h2: row_mask = `AMD_MASK_ROW2;
      4'h3: row_mask = `AMD_MASK_ROW3;
      4'h4, 4'h5: row_mask = `AMD_MASK_ROW45;
      4'h6, 4'h7: row_mask = `AMD_MASK_ROW67;
      4'h8: row_mask = `AMD_MASK_ROW8;
      4'h9: row_mask = `AMD_MASK_ROW9;
      4'hA, 4'hB: row_mask = `AMD_MASK_ROWAB;
      4'hC: row_mask = `AMD_MASK_ROWC;
      default: row_mask = `AMD_MASK_ROWDF;
    endcase
  endfunction

  logic [15:0] mask;
  logic [1:0] sub;
  logic stack_op;

  // Only the opcode byte feeds the decode
  assign mask = row_mask(opcode[`AMD_ROW_MSB:`AMD_ROW_LSB]); // RL19
  assign sub = opcode[`AMD_SUB_MSB:`AMD_SUB_LSB];
  assign stack_op = (opcode == `AMD_OPC_PULL_A) ||
                    (opcode == `AMD_OPC_PULL_B) ||
                    (opcode == `AMD_OPC_PUSH_A) ||
                    (opcode == `AMD_OPC_PUSH_B);

  // Mode and length; unassigned codes fall out as one-byte illegal
  always_comb begin
    dec = '0;
    dec.mode = AMD_MODE_ILL;
    dec.len = `AMD_LEN_ONE;
    dec.valid = mask[opcode[3:0]]; // RL20
    if (dec.valid) begin
      if ((opcode[`AMD_ROW_MSB:`AMD_ROW_LSB] == `AMD_ROW_REL) ||
          (opcode == `AMD_OPC_BR_SUB)) begin
        dec.mode = AMD_MODE_REL; // RL12
        dec.len = `AMD_LEN_TWO; // RL10
      end else if (opcode[`AMD_GRP_MSB:`AMD_GRP_LSB] == `AMD_GRP_LOW) begin
        if (stack_op) begin
          // Push and pull have no other form
          dec.mode = AMD_MODE_ACC; // RL2
          dec.acc_rd = opcode[`AMD_STK_ACCB_BIT] ? 2'h2 : 2'h1;
          dec.acc_wr = dec.acc_rd;
          if (opcode[2]) begin
            dec.acc_wr = 2'h0;
          end else begin
            dec.acc_rd = 2'h0;
          end
        end else begin
          dec.mode = AMD_MODE_INH; // RL4
        end
        if (opcode == `AMD_OPC_ADD_ACC) begin
          dec.acc_rd = 2'h3; // RL3
          dec.acc_wr = 2'h1; // RL3
        end
      end else if (opcode[`AMD_GRP_MSB:`AMD_GRP_LSB] == `AMD_GRP_SGL) begin
        // Jumps 6E and 7E land here as indexed or extended, never relative
        case (sub)
          `AMD_SUB_IMM, `AMD_SUB_DIR: begin
            dec.mode = AMD_MODE_ACC; // RL1
            dec.acc_rd = opcode[`AMD_ACCB_BIT] ? 2'h2 : 2'h1; // RL1
            dec.acc_wr = dec.acc_rd;
          end
          `AMD_SUB_IDX: begin
            dec.mode = AMD_MODE_IDX; // RL2 RL13
            dec.len = `AMD_LEN_TWO; // RL14
          end
          default: begin
            dec.mode = AMD_MODE_EXT; // RL2 RL13
            dec.len = `AMD_LEN_THREE; // RL18
          end
        endcase
      end else begin
        case (sub)
          `AMD_SUB_IMM: begin
            dec.mode = AMD_MODE_IMM;
            dec.wide = (opcode == `AMD_OPC_CMP_IDX) ||
                       (opcode == `AMD_OPC_LD_SP) ||
                       (opcode == `AMD_OPC_LD_IDX); // RL7
            dec.len = dec.wide ? `AMD_LEN_THREE : `AMD_LEN_TWO; // RL5 RL7
          end
          `AMD_SUB_DIR: begin
            dec.mode = AMD_MODE_DIR;
            dec.len = `AMD_LEN_TWO; // RL17
          end
          `AMD_SUB_IDX: begin
            dec.mode = AMD_MODE_IDX; // RL13
            dec.len = `AMD_LEN_TWO; // RL14
          end
          default: begin
            dec.mode = AMD_MODE_EXT; // RL13
            dec.len = `AMD_LEN_THREE; // RL18
          end
        endcase
      end
    end
  end

endmodule

`default_nettype wire

/* hw/amd_ea_calc.sv */
// Purpose: Forms operand value and effective address from the bytes.
// Assumes: Operand bytes are zero for lengths that do not carry them.
// Notes:   All sums are 16 bits and wrap past FFFF.
`include "amd_cfg.svh"
`default_nettype none

module amd_ea_calc (
  // Decoded instruction
  input wire amd_pkg::amd_mode_t mode,
  input wire logic wide,
  input wire logic [15:0] opc_addr,
  input wire logic [7:0] byte2,
  input wire logic [7:0] byte3,
  // Index register at execution
  input wire logic [15:0] index_reg,
  // Results
  output logic [15:0] operand,
  output logic [15:0] ea
);
  import amd_pkg::*;

  logic [15:0] disp;
  logic [15:0] offset;

  // Branch displacement is signed, index offset is not
  assign disp = {{8{byte2[7]}}, byte2}; // RL10
  assign offset = {8'h00, byte2}; // RL15

  // Immediate value: 8-bit zero extended or high byte first
  always_comb begin
    if (wide) begin
      operand = {byte2, byte3}; // RL7
    end else begin
      operand = {8'h00, byte2}; // RL5 RL6
    end
  end

  // Effective address per mode; carries past bit 15 are dropped
  always_comb begin
    case (mode)
      AMD_MODE_IMM: ea = 16'(opc_addr + `AMD_IMM_STEP); // RL8
      AMD_MODE_REL: ea = 16'(opc_addr + `AMD_REL_BIAS + disp); // RL11 RL21
      AMD_MODE_IDX: ea = 16'(index_reg + offset); // RL15 RL16 RL21
      AMD_MODE_DIR: ea = {`AMD_ZERO_PAGE, byte2}; // RL17
      AMD_MODE_EXT: ea = {byte2, byte3}; // RL18
      default: ea = 16'h0000;
    endcase
  end

endmodule

`default_nettype wire

/* sim/amd_decoder_monitor.sv */
// Purpose: Port-level assertions for the addressing mode decoder.
// Assumes: One clock domain; the bench holds index_reg per instruction.
// Notes:   Bound to amd_decoder at the foot of this file.
`default_nettype none

module amd_decoder_monitor (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Fetch side
  input wire logic fetch_valid,
  input wire amd_pkg::amd_fetch_t fetch_in,
  input wire logic fetch_ready,
  // Execution side
  input wire logic [15:0] index_reg,
  input wire logic res_ready,
  input wire logic res_valid,
  input wire amd_pkg::amd_res_t res,
  input wire logic illegal_q
);
  import amd_pkg::*;
  // ----
  // Helpers
  // ----
  amd_mode_t md;
  logic [15:0] rel_off;
  logic [7:0] op;
  assign md = res.dec.mode;
  assign op = res.opcode;
  // Offset from first byte plus 2; wraps so sign shows in the top bits
  assign rel_off = res.ea - res.opc_addr - 16'h0002;

  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  // ----
  // Assertions
  // ----
  a_short_forms: assert property (
    res_valid && md inside {AMD_MODE_INH, AMD_MODE_ACC, AMD_MODE_ILL}
    |-> res.dec.len == 2'h1 && res.ea == 16'h0000)
    else $error("one-byte form malformed");
  a_stack_acc: assert property (
    res_valid && op inside {8'h32, 8'h33, 8'h36, 8'h37} |-> md == AMD_MODE_ACC)
    else $error("stack op not accumulator mode");
  a_add_accs: assert property (
    res_valid && op == 8'h1B |-> md == AMD_MODE_INH &&
    res.dec.acc_rd == 2'h3 && res.dec.acc_wr == 2'h1)
    else $error("add accumulators misdecoded");
  a_imm_form: assert property (
    res_valid && md == AMD_MODE_IMM |-> res.ea == res.opc_addr + 16'h0001 &&
    res.dec.len == (res.dec.wide ? 2'h3 : 2'h2) &&
    (res.dec.wide || res.operand[15:8] == 8'h00))
    else $error("immediate form malformed");
  a_rel_form: assert property (
    res_valid && md == AMD_MODE_REL |-> res.dec.len == 2'h2 &&
    (rel_off <= 16'h007F || rel_off >= 16'hFF80))
    else $error("branch target out of range");
  a_rel_only: assert property (
    res_valid && md == AMD_MODE_REL |-> op[7:4] == 4'h2 || op == 8'h8D)
    else $error("relative mode on non-branch");
  a_jump_absolute: assert property (
    res_valid && op inside {8'h6E, 8'h7E, 8'hAD, 8'hBD} |-> md != AMD_MODE_REL)
    else $error("jump decoded as relative");
  a_idx_offset: assert property (
    res_valid && md == AMD_MODE_IDX |-> res.dec.len == 2'h2 &&
    res.ea - index_reg <= 16'h00FF)
    else $error("indexed address malformed");
  a_dir_page: assert property (
    res_valid && md == AMD_MODE_DIR |-> res.dec.len == 2'h2 &&
    res.ea[15:8] == 8'h00)
    else $error("direct address outside first page");
  a_ext_len: assert property (
    res_valid && md == AMD_MODE_EXT |-> res.dec.len == 2'h3)
    else $error("extended form not three bytes");
  a_res_hold: assert property (
    res_valid && !res_ready |=> res_valid && $stable(res) && !fetch_ready)
    else $error("result changed while held");
  a_illegal_flag: assert property (
    res_valid && md == AMD_MODE_ILL |-> ##[0:2] illegal_q)
    else $error("illegal opcode not flagged");
  a_illegal_stick: assert property (
    illegal_q |=> illegal_q)
    else $error("illegal flag dropped");

  // Main scenarios reached
  c_branch: cover property (res_valid && res_ready && md == AMD_MODE_REL);
  c_indexed: cover property (res_valid && res_ready && md == AMD_MODE_IDX);
  c_illegal: cover property (res_valid && md == AMD_MODE_ILL);
endmodule

bind amd_decoder amd_decoder_monitor i_mon (.clk(clk), .reset(reset),
  .fetch_valid(fetch_valid), .fetch_in(fetch_in), .fetch_ready(fetch_ready),
  .index_reg(index_reg), .res_ready(res_ready), .res_valid(res_valid),
  .res(res), .illegal_q(illegal_q));

`default_nettype wire

/* sim/amd_prog_mem.sv */
// Purpose: Program memory model feeding bytes to the decoder.
// Assumes: The bench loads mem and starts one instruction at a time.
// Notes:   A released data bus shows the inverse of the last byte.
`default_nettype none

module amd_prog_mem (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Control from the bench
  input wire logic start,
  input wire logic [15:0] start_pc,
  input wire logic [1:0] nbytes,
  input wire logic slow,
  // Byte stream
  input wire logic fetch_ready,
  output logic fetch_valid,
  output amd_pkg::amd_fetch_t fetch_in
);
  import amd_pkg::*;
  logic [7:0] mem [0:65535];
  logic [15:0] pc_q;
  logic [1:0] left_q;
  logic go;

  // ----
  // Offer bytes in program order, held until taken
  // ----
  always @(posedge clk) begin
    go = !slow || $urandom_range(1) == 1; // Slow mode leaves random gaps
    if (reset) begin
      fetch_valid <= 1'b0;
      left_q <= 2'h0;
      pc_q <= 16'h0000;
      fetch_in <= '0;
    end else if (start) begin
      pc_q <= start_pc;
      left_q <= nbytes;
    end else if ((!fetch_valid || fetch_ready) && left_q != 2'h0 && go) begin
      fetch_valid <= 1'b1;
      fetch_in.data <= mem[pc_q];
      fetch_in.addr <= pc_q;
      pc_q <= pc_q + 16'h0001;
      left_q <= left_q - 2'h1;
    end else if (fetch_valid && fetch_ready) begin
      fetch_valid <= 1'b0;
      fetch_in.data <= ~fetch_in.data;
    end
  end
endmodule

`default_nettype wire

/* sim/addressing_mode_decoder_tb_top.sv */
// Purpose: Self-checking bench for the addressing mode decoder.
// Assumes: Bench inputs change at the falling edge, fetch bytes at the rising; fixed random seed.
// Notes:   Expected decode is rebuilt here from the opcode map masks.
`include "amd_cfg.svh"
`default_nettype none

`define CHK(nm, e, g) \
  begin \
    checks_done++; \
    if ((g) !== (e)) begin \
      fail_count++; \
      $display("[ERR] %s exp %0h got %0h", nm, e, g); \
    end \
  end

module addressing_mode_decoder_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import amd_pkg::*;
  logic clk = 1'b0;
  logic reset = 1'b1, start = 1'b0, slow = 1'b0, res_ready = 1'b0;
  logic fetch_valid, fetch_ready, res_valid, illegal_q;
  logic [15:0] start_pc = 16'h0000, index_reg = 16'h0000;
  logic [1:0] nbytes = 2'h0;
  amd_fetch_t fetch_in;
  amd_res_t res;
  int fail_count = 0, checks_done = 0, n_valid = 0;

  always #20 clk = ~clk;

  amd_decoder i_dut (.clk(clk), .reset(reset), .fetch_valid(fetch_valid),
    .fetch_in(fetch_in), .fetch_ready(fetch_ready), .index_reg(index_reg),
    .res_ready(res_ready), .res_valid(res_valid), .res(res),
    .illegal_q(illegal_q));
  amd_prog_mem i_mem (.clk(clk), .reset(reset), .start(start),
    .start_pc(start_pc), .nbytes(nbytes), .slow(slow),
    .fetch_ready(fetch_ready), .fetch_valid(fetch_valid),
    .fetch_in(fetch_in));

  // ----
  // Reference decode
  // ----
  function automatic amd_mode_t ref_mode(input logic [7:0] op);
    logic [15:0] m;
    case (op[7:4])
      4'h0: m = `AMD_MASK_ROW0;
      4'h1: m = `AMD_MASK_ROW1;
      4'h2: m = `AMD_MASK_ROW2;
      4'h3: m = `AMD_MASK_ROW3;
      4'h4, 4'h5: m = `AMD_MASK_ROW45;
      4'h6, 4'h7: m = `AMD_MASK_ROW67;
      4'h8: m = `AMD_MASK_ROW8;
      4'h9: m = `AMD_MASK_ROW9;
      4'hA, 4'hB: m = `AMD_MASK_ROWAB;
      4'hC: m = `AMD_MASK_ROWC;
      default: m = `AMD_MASK_ROWDF;
    endcase
    if (!m[op[3:0]]) return AMD_MODE_ILL;
    if (op[7:4] == 4'h2 || op == 8'h8D) return AMD_MODE_REL;
    if (op inside {8'h32, 8'h33, 8'h36, 8'h37} || op[7:5] == 3'h2)
      return AMD_MODE_ACC;
    if (op[7:6] == 2'h0) return AMD_MODE_INH;
    if (op[7:4] == 4'h6) return AMD_MODE_IDX;
    if (op[7:4] == 4'h7) return AMD_MODE_EXT;
    case (op[5:4])
      2'h0: return AMD_MODE_IMM;
      2'h1: return AMD_MODE_DIR;
      2'h2: return AMD_MODE_IDX;
      default: return AMD_MODE_EXT;
    endcase
  endfunction

  // ----
  // One instruction: load, stream, compare, accept
  // ----
  task automatic run_instr(input logic [7:0] op, b2, b3,
                           input logic [15:0] pc, idx);
    amd_mode_t md;
    logic w, s;
    logic [1:0] ln, ar, aw;
    logic [15:0] ea, opd;
    int k;
    md = ref_mode(op);
    w = op inside {8'h8C, 8'h8E, 8'hCE};
    ln = md == AMD_MODE_EXT ? 2'h3 : md == AMD_MODE_IMM ? 2'h2 + {1'b0, w} :
         md inside {AMD_MODE_REL, AMD_MODE_IDX, AMD_MODE_DIR} ? 2'h2 : 2'h1;
    opd = md == AMD_MODE_IMM ? (w ? {b2, b3} : {8'h00, b2}) : 16'h0000;
    case (md)
      AMD_MODE_IMM: ea = pc + 16'h0001;
      AMD_MODE_REL: ea = pc + 16'h0002 + {{8{b2[7]}}, b2};
      AMD_MODE_IDX: ea = idx + {8'h00, b2};
      AMD_MODE_DIR: ea = {8'h00, b2};
      AMD_MODE_EXT: ea = {b2, b3};
      default: ea = 16'h0000;
    endcase
    // Accumulator masks: bit 0 is A, bit 1 is B
    s = op[7:6] == 2'h1 ? op[4] : op[0];
    ar = md == AMD_MODE_ACC && !(op inside {8'h32, 8'h33}) ? 2'h1 << s : 2'h0;
    aw = md == AMD_MODE_ACC && !(op inside {8'h36, 8'h37}) ? 2'h1 << s : 2'h0;
    if (op == 8'h1B) {ar, aw} = {2'h3, 2'h1};
    i_mem.mem[pc] = op;
    i_mem.mem[pc + 16'h0001] = b2;
    i_mem.mem[pc + 16'h0002] = b3;
    @(negedge clk);
    start_pc = pc;
    index_reg = idx;
    nbytes = ln;
    start = 1'b1;
    @(negedge clk);
    start = 1'b0;
    for (k = 0; k < 40 && res_valid !== 1'b1; k++) @(negedge clk);
    if (res_valid !== 1'b1) begin
      fail_count++;
      $display("[ERR] res_valid exp 1 got 0");
      summarize();
    end else begin
      `CHK("mode", md, res.dec.mode);
      `CHK("len", ln, res.dec.len);
      `CHK("valid", md != AMD_MODE_ILL, res.dec.valid);
      `CHK("opcode", op, res.opcode);
      `CHK("opc_addr", pc, res.opc_addr);
      `CHK("operand", opd, res.operand);
      `CHK("ea", ea, res.ea);
      `CHK("next_pc", pc + {14'h0, ln}, res.next_pc);
      `CHK("acc_rd", ar, res.dec.acc_rd);
      `CHK("acc_wr", aw, res.dec.acc_wr);
      `CHK("fetch_ready", 1'b0, fetch_ready);
      if (res.dec.valid === 1'b1) n_valid++;
      // Stall the taker for zero to two cycles so the result must stand
      repeat ($urandom_range(2)) @(negedge clk);
      res_ready = 1'b1;
      @(negedge clk);
      res_ready = 1'b0;
      `CHK("res_valid", 1'b0, res_valid);
      `CHK("fetch_ready", 1'b1, fetch_ready);
    end
  endtask

  task automatic summarize();
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // ----
  // Main sequence
  // ----
  initial begin
    void'($urandom(32'hA3AB3544));
    repeat (12) @(negedge clk);
    reset = 1'b0;
    // Every opcode once, random operands and placement
    for (int op = 0; op < 256; op++) begin
      slow = 1'($urandom_range(1));
      run_instr(8'(op), 8'($urandom), 8'($urandom), 16'($urandom),
                16'($urandom));
    end
    `CHK("valid count", 197, n_valid);
    `CHK("illegal_q", 1'b1, illegal_q);
    $display("test opcode_sweep done");
    // Boundary operands, back to back and with gaps
    slow = 1'b0;
    run_instr(8'h20, 8'h80, 8'h00, 16'h0010, 16'h0000);
    run_instr(8'h20, 8'h7F, 8'h00, 16'hFFF0, 16'h0000);
    run_instr(8'h8D, 8'hFE, 8'h00, 16'h4000, 16'h0000);
    run_instr(8'h6E, 8'h00, 8'h00, 16'h0200, 16'h1234);
    run_instr(8'hA6, 8'hFF, 8'h00, 16'h0300, 16'hFFF0);
    run_instr(8'hCE, 8'hFF, 8'hFF, 16'h0400, 16'h0000);
    run_instr(8'h86, 8'hFF, 8'h00, 16'h0500, 16'h0000);
    run_instr(8'h86, 8'h41, 8'h00, 16'h0502, 16'h0000);
    slow = 1'b1;
    run_instr(8'h96, 8'hFF, 8'h00, 16'h0600, 16'h0000);
    run_instr(8'h7E, 8'h12, 8'h34, 16'hFFFE, 16'h0000);
    run_instr(8'h4F, 8'h00, 8'h00, 16'h0700, 16'h0000);
    run_instr(8'h1B, 8'h00, 8'h00, 16'h0701, 16'h0000);
    $display("test corners done");
    // Reset in mid-instruction clears the flag and the result
    @(negedge clk);
    start_pc = 16'hFFFE;
    nbytes = 2'h3;
    start = 1'b1;
    @(negedge clk);
    start = 1'b0;
    repeat (2) @(negedge clk);
    reset = 1'b1;
    @(negedge clk);
    reset = 1'b0;
    `CHK("illegal_q", 1'b0, illegal_q);
    `CHK("res_valid", 1'b0, res_valid);
    `CHK("fetch_ready", 1'b1, fetch_ready);
    run_instr(8'h32, 8'h00, 8'h00, 16'h0800, 16'h0000);
    $display("test mid_reset done");
    summarize();
  end
endmodule

`default_nettype wire
